// ==== pkg/timer16_defs.vh ====
// register map, field positions, reset values and mode codes of the 16-bit timer core
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define OFS_CTRL_A      8'h00
`define OFS_CTRL_B      8'h04
`define OFS_CNT_LOW     8'h08
`define OFS_CNT_HIGH    8'h0c
`define OFS_CAP_LOW     8'h10
`define OFS_CAP_HIGH    8'h14
`define OFS_FLAGS       8'h18
`define OFS_IRQ_EN      8'h1c
`define OFS_CMP_CTRL    8'h20
// ----------------------------------------
// field positions
// ----------------------------------------
`define CSEL_LSB        0
`define CSEL_MSB        2
`define WMODE_A_LSB     0
`define WMODE_A_MSB     1
`define WMODE_B_LSB     3
`define WMODE_B_MSB     4
`define EDGE_RISE_BIT   6
`define FILT_EN_BIT     7
`define OVF_BIT         0
`define CAP_BIT         1
`define CMP_SEL_BIT     0
// ----------------------------------------
// clock select codes
// ----------------------------------------
`define CSEL_STOP       3'h0
`define CSEL_SYS        3'h1
`define CSEL_PRE_FIRST  3'h2
`define CSEL_PRE_LAST   3'h5
`define CSEL_EXT_FALL   3'h6
`define CSEL_EXT_RISE   3'h7
// ----------------------------------------
// waveform modes with special counting
// ----------------------------------------
`define WM_PC_CAP       4'h8
`define WM_PFC_CAP      4'ha
`define WM_CTC_CAP      4'hc
`define WM_FAST_CAP     4'he
// ----------------------------------------
// values and responses
// ----------------------------------------
`define CNT_MAX         16'hffff
`define CNT_ZERO        16'h0000
`define CNT_STEP        16'h0001
`define BYTE_ZERO       8'h00
`define FILT_ALL_ONE    4'hf
`define FILT_ALL_ZERO   4'h0
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// ==== hdl/timer16_counter_input_capture.v ====
// counting core and input capture unit of a 16-bit timer with an axi4-lite register slave
`timescale 1ns/1ps
`include "timer16_defs.vh"

module timer16_counter_input_capture #(
  parameter ADDR_W   = 8,
  parameter INSTANCE = 1
) (
  input  wire              clk,
  input  wire              reset,
  input  wire              ce,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire [3:0]        prescale_tick,
  input  wire              external_count_pin,
  input  wire              capture_pin,
  input  wire              comparator_output,
  input  wire              overflow_ack,
  input  wire              capture_ack,
  output reg               overflow_irq,
  output reg               capture_irq,
  output reg               count_zero,
  output reg               count_maximum
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function uses_cap_top;
    input [3:0] m;
    begin
      uses_cap_top = (m == `WM_PC_CAP) || (m == `WM_PFC_CAP) ||
                     (m == `WM_CTC_CAP) || (m == `WM_FAST_CAP);
    end
  endfunction
  function is_up_down;
    input [3:0] m;
    begin
      is_up_down = (m == `WM_PC_CAP) || (m == `WM_PFC_CAP);
    end
  endfunction
  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [7:0]        ctrl_a_q;
  reg  [7:0]        ctrl_b_q;
  reg               cmp_sel_q;
  reg  [1:0]        irq_en_q;
  reg  [15:0]       cnt_q;
  reg  [15:0]       cnt_d;
  reg               dir_up_q;
  reg               dir_up_d;
  reg  [15:0]       cap_q;
  reg  [7:0]        hold_q;
  reg               ovf_flag_q;
  reg               cap_flag_q;
  reg               ext_prev_q;
  reg               trig_s_q;
  reg  [3:0]        hist_q;
  reg               filt_q;
  reg               edge_prev_q;
  reg               aw_v_q;
  reg  [ADDR_W-1:0] aw_a_q;
  reg               w_v_q;
  reg  [31:0]       wd_q;
  reg  [3:0]        ws_q;
  reg               ovf_evt;
  reg  [31:0]       rd_mux;
  reg               rd_hit;
  wire [3:0]  wmode   = {ctrl_b_q[`WMODE_B_MSB:`WMODE_B_LSB], ctrl_a_q[`WMODE_A_MSB:`WMODE_A_LSB]};
  wire [2:0]  csel    = ctrl_b_q[`CSEL_MSB:`CSEL_LSB];
  wire        cap_top = uses_cap_top(wmode);
  wire [15:0] top     = cap_top ? cap_q : `CNT_MAX;
  // ----------------------------------------
  // bus strobes
  // ----------------------------------------
  wire       wr_en   = ce & aw_v_q & w_v_q & ~s_axi_bvalid & ws_q[0];
  wire       wr_any  = ce & aw_v_q & w_v_q & ~s_axi_bvalid;
  wire       rd_en   = ce & s_axi_arvalid & s_axi_arready;
  wire [7:0] wbyte   = wd_q[7:0];
  wire       wr_clo  = wr_en & (aw_a_q == `OFS_CNT_LOW);
  wire       wr_chi  = wr_en & (aw_a_q == `OFS_CNT_HIGH);
  wire       wr_plo  = wr_en & (aw_a_q == `OFS_CAP_LOW);
  wire       wr_phi  = wr_en & (aw_a_q == `OFS_CAP_HIGH);
  wire       wr_flg  = wr_en & (aw_a_q == `OFS_FLAGS);
  wire       rd_clo  = rd_en & (s_axi_araddr == `OFS_CNT_LOW);
  wire       rd_plo  = rd_en & (s_axi_araddr == `OFS_CAP_LOW);
  wire       wr_map  = (aw_a_q == `OFS_CTRL_A) || (aw_a_q == `OFS_CTRL_B) ||
                       (aw_a_q == `OFS_CNT_LOW) || (aw_a_q == `OFS_CNT_HIGH) ||
                       (aw_a_q == `OFS_CAP_LOW) || (aw_a_q == `OFS_CAP_HIGH) ||
                       (aw_a_q == `OFS_FLAGS) || (aw_a_q == `OFS_IRQ_EN) ||
                       (aw_a_q == `OFS_CMP_CTRL);
  // ----------------------------------------
  // tick selection
  // ----------------------------------------
  wire [2:0] pre_off = csel - `CSEL_PRE_FIRST;
  wire [1:0] pre_idx = pre_off[1:0];
  wire       tick    = (csel == `CSEL_SYS) |
                       ((csel >= `CSEL_PRE_FIRST) && (csel <= `CSEL_PRE_LAST) && prescale_tick[pre_idx]) |
                       ((csel == `CSEL_EXT_FALL) && ext_prev_q && !external_count_pin) |
                       ((csel == `CSEL_EXT_RISE) && !ext_prev_q && external_count_pin);
  // ----------------------------------------
  // capture path
  // ----------------------------------------
  // comparator path tied off by parameter so only instance one can use it
  wire cmp_ok   = (INSTANCE == 1);
  wire trig_raw = (cmp_sel_q && cmp_ok) ? comparator_output : capture_pin;
  wire filt_en  = ctrl_b_q[`FILT_EN_BIT];
  wire det_in   = filt_en ? filt_q : trig_s_q;
  wire rise_sel = ctrl_b_q[`EDGE_RISE_BIT];
  wire cap_evt  = !cap_top &&
                  (rise_sel ? (det_in && !edge_prev_q) : (!det_in && edge_prev_q));

  // ----------------------------------------
  // counter next value
  // ----------------------------------------
  always @*
  begin
    cnt_d    = cnt_q;
    dir_up_d = dir_up_q;
    ovf_evt  = 1'b0;
    if (tick)
    begin
      if (is_up_down(wmode))
      begin
        if (dir_up_q)
        begin
          if (cnt_q >= top)
          begin
            dir_up_d = 1'b0;
            cnt_d    = cnt_q - `CNT_STEP;
          end
          else
            cnt_d = cnt_q + `CNT_STEP;
        end
        else if (cnt_q == `CNT_ZERO)
        begin
          dir_up_d = 1'b1;
          cnt_d    = cnt_q + `CNT_STEP;
          ovf_evt  = 1'b1;
        end
        else
          cnt_d = cnt_q - `CNT_STEP;
      end
      else
      begin
        dir_up_d = 1'b1;
        ovf_evt  = (cnt_q == `CNT_MAX) || ((wmode == `WM_FAST_CAP) && (cnt_q >= top));
        if (cnt_q >= top)
          cnt_d = `CNT_ZERO;
        else
          cnt_d = cnt_q + `CNT_STEP;
      end
    end
    // software load wins over tick, also with the tick stopped
    if (wr_clo)
      cnt_d = {hold_q, wbyte};
  end
  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @*
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `OFS_CTRL_A:   rd_mux[7:0] = ctrl_a_q;
      `OFS_CTRL_B:   rd_mux[7:0] = ctrl_b_q;
      `OFS_CNT_LOW:  rd_mux[7:0] = cnt_q[7:0];
      `OFS_CNT_HIGH: rd_mux[7:0] = hold_q;
      `OFS_CAP_LOW:  rd_mux[7:0] = cap_q[7:0];
      `OFS_CAP_HIGH: rd_mux[7:0] = hold_q;
      `OFS_FLAGS:
      begin
        rd_mux[`OVF_BIT] = ovf_flag_q;
        rd_mux[`CAP_BIT] = cap_flag_q;
      end
      `OFS_IRQ_EN:   rd_mux[1:0] = irq_en_q;
      `OFS_CMP_CTRL: rd_mux[`CMP_SEL_BIT] = cmp_sel_q;
      default:       rd_hit = 1'b0;
    endcase
  end
  // ----------------------------------------
  // registers and counter
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      ctrl_a_q   <= `BYTE_ZERO;
      ctrl_b_q   <= `BYTE_ZERO;
      cmp_sel_q  <= 1'b0;
      irq_en_q   <= 2'h0;
      cnt_q      <= `CNT_ZERO;
      dir_up_q   <= 1'b1;
      cap_q      <= `CNT_ZERO;
      hold_q     <= `BYTE_ZERO;
      ovf_flag_q <= 1'b0;
      cap_flag_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      ext_prev_q <= external_count_pin;
      cnt_q      <= cnt_d;
      dir_up_q   <= dir_up_d;
      if (wr_en && (aw_a_q == `OFS_CTRL_A))
        ctrl_a_q <= wbyte;
      if (wr_en && (aw_a_q == `OFS_CTRL_B))
        ctrl_b_q <= wbyte;
      if (wr_en && (aw_a_q == `OFS_IRQ_EN))
        irq_en_q <= wbyte[1:0];
      if (wr_en && (aw_a_q == `OFS_CMP_CTRL))
        cmp_sel_q <= wbyte[`CMP_SEL_BIT];
      // one holding byte for all wide locations; a same-cycle high write wins
      if (rd_clo)
        hold_q <= cnt_q[15:8];
      if (rd_plo)
        hold_q <= cap_q[15:8];
      if (wr_chi || wr_phi)
        hold_q <= wbyte;
      if (cap_evt)
        cap_q <= cnt_q;
      else if (wr_plo && cap_top)
        cap_q <= {hold_q, wbyte};
      // hardware set beats a same-cycle clear
      if (ovf_evt)
        ovf_flag_q <= 1'b1;
      else if (overflow_ack || (wr_flg && wbyte[`OVF_BIT]))
        ovf_flag_q <= 1'b0;
      if (cap_evt)
        cap_flag_q <= 1'b1;
      else if (capture_ack || (wr_flg && wbyte[`CAP_BIT]))
        cap_flag_q <= 1'b0;
    end
  end
  // ----------------------------------------
  // trigger sampling, filter, edge detector
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      trig_s_q    <= 1'b0;
      hist_q      <= `FILT_ALL_ZERO;
      filt_q      <= 1'b0;
      edge_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      trig_s_q <= trig_raw;
      hist_q   <= {hist_q[2:0], trig_s_q};
      if (hist_q == `FILT_ALL_ONE)
        filt_q <= 1'b1;
      else if (hist_q == `FILT_ALL_ZERO)
        filt_q <= 1'b0;
      edge_prev_q <= det_in;
    end
  end
  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      overflow_irq  <= 1'b0;
      capture_irq   <= 1'b0;
      count_zero    <= 1'b1;
      count_maximum <= 1'b0;
    end
    else if (ce)
    begin
      overflow_irq  <= ovf_flag_q & irq_en_q[`OVF_BIT];
      capture_irq   <= cap_flag_q & irq_en_q[`CAP_BIT];
      count_zero    <= (cnt_d == `CNT_ZERO);
      count_maximum <= (cnt_d == top);
    end
  end
  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_v_q        <= 1'b0;
      w_v_q         <= 1'b0;
      aw_a_q        <= {ADDR_W{1'b0}};
      wd_q          <= 32'h0000_0000;
      ws_q          <= 4'h0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_v_q        <= 1'b1;
        aw_a_q        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_v_q        <= 1'b1;
        wd_q         <= s_axi_wdata;
        ws_q         <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_any)
      begin
        aw_v_q       <= 1'b0;
        w_v_q        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  // reads have side effects, so the data is frozen at acceptance
  always @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else if (ce)
    begin
      if (rd_en)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // timer16_counter_input_capture

// ==== tb/timer16_checker_assertions.sv ====
// concurrent checks on the ports of the 16-bit timer core
`timescale 1ns/1ps
module timer16_checker (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        capture_pin,
  input wire logic        comparator_output,
  input wire logic        overflow_ack,
  input wire logic        capture_ack,
  input wire logic        overflow_irq,
  input wire logic        capture_irq,
  input wire logic        count_zero
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ----------------------------------------
  // steps
  // ----------------------------------------
  sequence aw_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
  endsequence
  sequence ar_take;
    s_axi_arvalid && s_axi_arready && ce;
  endsequence
  // quiet triggers, so an ack cannot race a fresh capture
  sequence cap_quiet;
    ($stable(capture_pin) && $stable(comparator_output) && ce) [*8];
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  chk_reset_state: assert property (@(posedge clk) disable iff (1'b0) reset && ce |=> s_axi_awready && s_axi_arready
    && !s_axi_bvalid && !s_axi_rvalid && count_zero && !capture_irq && !overflow_irq) else $error("reset state wrong");
  chk_write_answer: assert property (aw_w_take |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  chk_read_answer: assert property (ar_take |=> s_axi_rvalid)
    else $error("read answer missing");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  chk_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  chk_byte_lane: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bytes not zero");
  chk_ack_clears: assert property (cap_quiet ##0 capture_ack |=> ##1 !capture_irq)
    else $error("capture ack did not clear");
  chk_cap_fall: assert property ($fell(capture_irq) |-> $past(capture_ack) || $past(capture_ack, 2)
    || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("capture request fell alone");
  chk_ovf_fall: assert property ($fell(overflow_irq) |-> $past(overflow_ack) || $past(overflow_ack, 2)
    || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("overflow request fell alone");
endmodule // timer16_checker

bind timer16_counter_input_capture timer16_checker u_timer16_checker (.clk, .reset, .ce, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .capture_pin, .comparator_output, .overflow_ack,
  .capture_ack, .overflow_irq, .capture_irq, .count_zero);

// ==== tb/event_pins.sv ====
// port logic model of the event and tick pins beside the timer
`timescale 1ns/1ps
module event_pins (
  input  wire logic       clk,
  input  wire logic       pin_drive,
  input  wire logic       cmp_drive,
  input  wire logic       ext_drive,
  input  wire logic       tick_go,
  output logic            capture_pin,
  output logic            comparator_output,
  output logic            external_count_pin,
  output logic [3:0]      prescale_tick
);
  initial
  begin
    capture_pin = 1'b0;
    comparator_output = 1'b0;
    external_count_pin = 1'b0;
    prescale_tick = 4'h0;
  end
  // port latch: a pin written by software shows one clock later
  always @(posedge clk)
  begin
    capture_pin <= pin_drive;
    comparator_output <= cmp_drive;
    external_count_pin <= ext_drive;
    prescale_tick <= {3'h0, tick_go};
  end
endmodule // event_pins

// ==== tb/timer16_counter_input_capture_tb_top.sv ====
// self-checking bench for the 16-bit timer counting and capture core
`timescale 1ns/1ps
`include "timer16_defs.vh"
`define CHK(g, e) begin compares++; ev = (e); if ((g) !== ev) begin err_count++; $display("ERROR t=%0t got=%h exp=%h", $time, g, ev); end end
module timer16_counter_input_capture_tb_top;
  logic        clk = 1'b0, reset = 1'b1, ce = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, overflow_ack = 1'b0, capture_ack = 1'b0;
  logic        pin_drive = 1'b0, cmp_drive = 1'b0, ext_drive = 1'b0, tick_go = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [9:0]  ev;
  logic [9:0]  rq[$];
  logic [1:0]  bq[$];
  logic [15:0] v;
  int          err_count = 0, compares = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, overflow_irq, capture_irq;
  wire         count_zero, count_maximum, capture_pin, comparator_output, external_count_pin;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [3:0]   prescale_tick;

  always #4 clk = ~clk;

  timer16_counter_input_capture #(.ADDR_W(8), .INSTANCE(1)) u_timer16_counter_input_capture (.clk, .reset, .ce,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prescale_tick, .external_count_pin, .capture_pin,
    .comparator_output, .overflow_ack, .capture_ack, .overflow_irq, .capture_irq, .count_zero, .count_maximum);
  event_pins u_event_pins (.clk, .pin_drive, .cmp_drive, .ext_drive, .tick_go, .capture_pin, .comparator_output,
    .external_count_pin, .prescale_tick);
  // ----------------------------------------
  // bus tasks, called right after a rising edge
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = `RESP_OKAY);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = `RESP_OKAY);
    rq.push_back({r, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  // high location first on writes, low location first on reads
  task automatic wr16(input logic [7:0] lo, input logic [15:0] d);
    wr(lo + 8'h04, d[15:8]);
    wr(lo, d[7:0]);
  endtask
  task automatic rd16(input logic [7:0] lo, input logic [15:0] e);
    rd(lo, e[7:0]);
    rd(lo + 8'h04, e[15:8]);
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      tick_go <= 1'b1;
      @(posedge clk);
      tick_go <= 1'b0;
      repeat (5) @(posedge clk);
    end
  endtask
  // long enough for the filtered path as well
  task automatic lv(input logic p, input logic c);
    pin_drive <= p;
    cmp_drive <= c;
    repeat (14) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      `CHK({s_axi_rresp, s_axi_rdata[7:0]}, rq.pop_front())
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      `CHK(s_axi_bresp, bq.pop_front())
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    void'($urandom(4324));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(`OFS_CTRL_B, 8'h00);
    rd16(`OFS_CNT_LOW, 16'h0000);
    rd(8'h40, 8'h00, `RESP_SLVERR);
    wr(8'h40, 8'h5a, `RESP_SLVERR);
    repeat (3)
    begin
      v = 16'($urandom);
      wr16(`OFS_CNT_LOW, v);
      rd16(`OFS_CNT_LOW, v);
    end
    wr16(`OFS_CNT_LOW, 16'h00fe);
    wr(`OFS_CTRL_B, 8'h02);
    tick(3);
    wr(`OFS_CTRL_B, 8'h07);
    repeat (2)
    begin
      ext_drive <= 1'b1;
      repeat (4) @(posedge clk);
      ext_drive <= 1'b0;
      repeat (4) @(posedge clk);
    end
    wr(`OFS_CTRL_B, 8'h00);
    rd16(`OFS_CNT_LOW, 16'h0103);
    // ticks offered while the enable is low must not move the counter
    wr(`OFS_CTRL_B, 8'h02);
    ce <= 1'b0;
    tick(2);
    ce <= 1'b1;
    wr(`OFS_CTRL_B, 8'h00);
    rd16(`OFS_CNT_LOW, 16'h0103);
    wr(`OFS_IRQ_EN, 8'h01);
    wr16(`OFS_CNT_LOW, 16'hffff);
    `CHK(count_maximum, 1'b1)
    wr(`OFS_CTRL_B, 8'h02);
    tick(1);
    `CHK(count_zero, 1'b1)
    `CHK(overflow_irq, 1'b1)
    wr(`OFS_CTRL_B, 8'h00);
    rd(`OFS_FLAGS, 8'h01);
    overflow_ack <= 1'b1;
    @(posedge clk);
    overflow_ack <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(overflow_irq, 1'b0)
    wr(`OFS_IRQ_EN, 8'h02);
    wr(`OFS_CTRL_B, 8'h40);
    wr16(`OFS_CNT_LOW, 16'h1234);
    lv(1'b1, 1'b0);
    `CHK(capture_irq, 1'b1)
    capture_ack <= 1'b1;
    @(posedge clk);
    capture_ack <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(capture_irq, 1'b0)
    rd16(`OFS_CAP_LOW, 16'h1234);
    wr16(`OFS_CNT_LOW, 16'h5678);
    lv(1'b0, 1'b0);
    rd(`OFS_FLAGS, 8'h00);
    lv(1'b1, 1'b0);
    wr16(`OFS_CNT_LOW, 16'h9abc);
    lv(1'b0, 1'b0);
    lv(1'b1, 1'b0);
    rd16(`OFS_CAP_LOW, 16'h9abc);
    wr(`OFS_FLAGS, 8'h02);
    rd(`OFS_FLAGS, 8'h00);
    wr(`OFS_CTRL_B, 8'hc0);
    lv(1'b0, 1'b0);
    pin_drive <= 1'b1;
    repeat (2) @(posedge clk);
    lv(1'b0, 1'b0);
    rd(`OFS_FLAGS, 8'h00);
    lv(1'b1, 1'b0);
    rd(`OFS_FLAGS, 8'h02);
    wr16(`OFS_CAP_LOW, 16'h1122);
    rd16(`OFS_CAP_LOW, 16'h9abc);
    wr(`OFS_FLAGS, 8'h02);
    wr(`OFS_CTRL_B, 8'h18);
    wr16(`OFS_CAP_LOW, 16'habcd);
    lv(1'b0, 1'b0);
    lv(1'b1, 1'b0);
    rd(`OFS_FLAGS, 8'h00);
    rd16(`OFS_CAP_LOW, 16'habcd);
    wr(`OFS_CTRL_B, 8'h40);
    wr(`OFS_CMP_CTRL, 8'h01);
    repeat (4) @(posedge clk);
    wr(`OFS_FLAGS, 8'h02);
    lv(1'b0, 1'b1);
    rd(`OFS_FLAGS, 8'h02);
    wr(`OFS_FLAGS, 8'h02);
    lv(1'b1, 1'b0);
    rd(`OFS_FLAGS, 8'h00);
    // up/down mode bounded by capture value: 3,4,3,2,1,0 then turn at bottom
    wr(`OFS_CTRL_B, 8'h12);
    wr16(`OFS_CAP_LOW, 16'h0004);
    wr16(`OFS_CNT_LOW, 16'h0003);
    tick(6);
    wr(`OFS_CTRL_B, 8'h10);
    rd16(`OFS_CNT_LOW, 16'h0001);
    rd(`OFS_FLAGS, 8'h01);
    wrap_up();
  end
endmodule // timer16_counter_input_capture_tb_top
